// file: rtl/sbf_pkg.sv
// Purpose: Shared constants and types for the serial-bus request fetch agent.
// Assumes: Command blocks arrive as a 10-byte descriptor, byte 0 in the top bits.
// Notes: Sense values are the only codes the agent builds itself.
package sbf_pkg;
    // ==========================================================
    // Widths
    localparam int ADDR_W = 48;
    localparam int CDB_W = 80;
    localparam int TAG_W = 4;
    localparam int LEN_W = 24;
    // ==========================================================
    // Descriptor field positions
    localparam int OPC_HI = 79;
    localparam int OPC_LO = 72;
    localparam int MODE_HI = 66;
    localparam int MODE_LO = 64;
    localparam int LEN_HI = 31;
    localparam int LEN_LO = 8;
    localparam int CTRL_HI = 7;
    localparam int CTRL_LO = 0;
    // ==========================================================
    // Codes
    localparam logic [7:0] OPC_WRITE_BUFFER = 8'h3b;
    localparam logic [2:0] MODE_DL_SAVE = 3'b101;
    localparam logic [7:0] CTRL_ZERO = 8'h00;
    localparam logic [3:0] SK_UNIT_ATTN = 4'h6;
    localparam logic [7:0] ASC_UCODE_CHANGED = 8'h3f;
    localparam logic [7:0] ASCQ_UCODE_CHANGED = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 48'h0;
    // ==========================================================
    // Agent states
    typedef enum logic [1:0] {CA_RESET, CA_ACTIVE, CA_SUSPENDED} sbf_cmd_state_t;
    typedef enum logic [1:0] {MA_RESET, MA_FETCH, MA_LOGGED} sbf_mgmt_state_t;
endpackage : sbf_pkg

// file: rtl/sbf_fetch_agent.sv
// Purpose: Device-side login, command agent and request fetch with status return.
// Assumes: Bus transactions are performed by an outer link layer via these strobes.
// Notes: Nonvolatile storage itself is outside; nvCommit asks it to keep the image.
module sbf_fetch_agent #(
    parameter int DEPTH = 8,
    parameter int NINIT = 4,
    parameter logic [sbf_pkg::ADDR_W-1:0] CMD_AGENT_BASE = 48'h0000_0001_0000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic busReset,
    // Register writes from the link
    input wire logic mgmtWr,
    input wire logic [sbf_pkg::ADDR_W-1:0] mgmtAddr,
    input wire logic orbPtrWr,
    input wire logic [sbf_pkg::ADDR_W-1:0] orbPtrAddr,
    input wire logic doorbellWr,
    // Login block fetch
    output logic loginFetchReq,
    output logic [sbf_pkg::ADDR_W-1:0] loginFetchAddr,
    input wire logic loginDone,
    input wire logic [31:0] loginPassword,
    input wire logic [sbf_pkg::ADDR_W-1:0] loginRespAddrIn,
    input wire logic [sbf_pkg::ADDR_W-1:0] loginStatusAddrIn,
    input wire logic [$clog2(NINIT)-1:0] loginInitId,
    input wire logic [31:0] currentPassword,
    input wire logic [31:0] masterPassword,
    // Login answer
    output logic loginRespValid,
    output logic loginReject,
    output logic [sbf_pkg::ADDR_W-1:0] loginRespAddr,
    output logic [sbf_pkg::ADDR_W-1:0] loginCmdBase,
    // Request fetch
    output logic fetchReq,
    output logic fetchLinkOnly,
    output logic [sbf_pkg::ADDR_W-1:0] fetchAddr,
    input wire logic fetchDone,
    input wire logic fetchNextNull,
    input wire logic [sbf_pkg::ADDR_W-1:0] fetchNext,
    input wire logic [sbf_pkg::CDB_W-1:0] fetchCdb,
    // Execution engine
    output logic execValid,
    output logic [sbf_pkg::TAG_W-1:0] execTag,
    output logic [sbf_pkg::CDB_W-1:0] execCdb,
    output logic [sbf_pkg::LEN_W-1:0] execMaxLen,
    input wire logic execDone,
    input wire logic [sbf_pkg::TAG_W-1:0] execDoneTag,
    input wire logic execOk,
    input wire logic [3:0] execSenseKey,
    // Read data toward initiator memory
    input wire logic rdValid,
    input wire logic [31:0] rdData,
    output logic blkWrValid,
    output logic [31:0] blkWrData,
    // Status blocks
    output logic statusValid,
    output logic [sbf_pkg::ADDR_W-1:0] statusAddr,
    output logic [sbf_pkg::TAG_W-1:0] statusTag,
    output logic [3:0] statusSenseKey,
    // Microcode save and attention
    input wire logic [NINIT-1:0] unsolEnable,
    output logic nvCommit,
    output logic uaValid,
    output logic [NINIT-1:0] uaMask,
    output logic [3:0] uaSenseKey,
    output logic [7:0] uaAsc,
    output logic [7:0] uaAscq,
    // Agent state
    output logic [1:0] cmdState
);
    import sbf_pkg::*;

    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    // ==========================================================
    // Management agent
    sbf_mgmt_state_t mgmtState_q;
    logic [ADDR_W-1:0] statusFifo_q;
    logic [$clog2(NINIT)-1:0] ownerId_q;
    logic passOk;

    assign passOk = (loginPassword == currentPassword) || (loginPassword == masterPassword);

    // Login is a two-step exchange: fetch block, then answer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mgmtState_q <= MA_RESET;
            loginFetchReq <= 1'b0;
            loginFetchAddr <= ADDR_ZERO;
            loginRespValid <= 1'b0;
            loginReject <= 1'b0;
            loginRespAddr <= ADDR_ZERO;
            loginCmdBase <= ADDR_ZERO;
            statusFifo_q <= ADDR_ZERO;
            ownerId_q <= '0;
        end else begin
            loginFetchReq <= 1'b0;
            loginRespValid <= 1'b0;
            loginReject <= 1'b0;
            if (busReset) begin
                mgmtState_q <= MA_RESET;
            end else begin
                unique case (mgmtState_q)
                    MA_RESET: begin
                        if (mgmtWr) begin
                            loginFetchReq <= 1'b1;
                            loginFetchAddr <= mgmtAddr;
                            mgmtState_q <= MA_FETCH;
                        end
                    end
                    MA_FETCH: begin
                        if (loginDone && passOk) begin
                            loginRespValid <= 1'b1;
                            loginRespAddr <= loginRespAddrIn;
                            loginCmdBase <= CMD_AGENT_BASE;
                            statusFifo_q <= loginStatusAddrIn;
                            ownerId_q <= loginInitId;
                            mgmtState_q <= MA_LOGGED;
                        end else if (loginDone) begin
                            loginReject <= 1'b1;
                            mgmtState_q <= MA_RESET;
                        end
                    end
                    MA_LOGGED: begin
                        mgmtState_q <= MA_LOGGED;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Command agent and fetch engine
    sbf_cmd_state_t cmdState_q;
    logic fetchBusy_q;
    logic nullSeen_q;
    logic relink_q;
    logic bellLate_q;
    logic [ADDR_W-1:0] nextAddr_q;
    logic [ADDR_W-1:0] lastAddr_q;
    logic [CNT_W-1:0] inFlight_q;
    logic [TAG_W-1:0] tagNext_q;
    logic canFetch;
    logic dispatch;
    logic retire;
    logic isUcode;

    assign canFetch = (cmdState_q == CA_ACTIVE) && !nullSeen_q && !fetchBusy_q && (inFlight_q != CNT_FULL);
    assign dispatch = fetchDone && fetchBusy_q && !relink_q;
    assign retire = execDone && (inFlight_q != '0);
    assign isUcode = (fetchCdb[OPC_HI:OPC_LO] == OPC_WRITE_BUFFER)
        && (fetchCdb[MODE_HI:MODE_LO] == MODE_DL_SAVE)
        && (fetchCdb[CTRL_HI:CTRL_LO] == CTRL_ZERO);

    // State walk: Reset -> Active -> Suspended -> Active on doorbell
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmdState_q <= CA_RESET;
            fetchBusy_q <= 1'b0;
            nullSeen_q <= 1'b0;
            relink_q <= 1'b0;
            bellLate_q <= 1'b0;
            nextAddr_q <= ADDR_ZERO;
            lastAddr_q <= ADDR_ZERO;
            fetchReq <= 1'b0;
            fetchLinkOnly <= 1'b0;
            fetchAddr <= ADDR_ZERO;
        end else begin
            fetchReq <= 1'b0;
            if (busReset) begin
                cmdState_q <= CA_RESET;
                fetchBusy_q <= 1'b0;
                nullSeen_q <= 1'b0;
                relink_q <= 1'b0;
                bellLate_q <= 1'b0;
            end else begin
                unique case (cmdState_q)
                    CA_RESET: begin
                        // Doorbell has no effect here
                        if (orbPtrWr && mgmtState_q == MA_LOGGED) begin
                            cmdState_q <= CA_ACTIVE;
                            nextAddr_q <= orbPtrAddr;
                            nullSeen_q <= 1'b0;
                        end
                    end
                    CA_ACTIVE: begin
                        // A bell after the null link is held for the suspend point; earlier ones drop
                        if (doorbellWr && nullSeen_q && !relink_q) begin
                            bellLate_q <= 1'b1;
                        end
                        if (canFetch) begin
                            fetchReq <= 1'b1;
                            fetchLinkOnly <= 1'b0;
                            fetchAddr <= nextAddr_q;
                            fetchBusy_q <= 1'b1;
                        end
                        if (fetchDone && fetchBusy_q) begin
                            fetchBusy_q <= 1'b0;
                            relink_q <= 1'b0;
                            if (!relink_q) begin
                                lastAddr_q <= fetchAddr;
                            end
                            if (fetchNextNull) begin
                                nullSeen_q <= 1'b1;
                            end else begin
                                nextAddr_q <= fetchNext;
                            end
                        end
                        // Suspend only once every fetched command has retired
                        if (nullSeen_q && !fetchBusy_q && inFlight_q == '0) begin
                            cmdState_q <= CA_SUSPENDED;
                        end
                    end
                    CA_SUSPENDED: begin
                        if (doorbellWr || bellLate_q) begin
                            cmdState_q <= CA_ACTIVE;
                            bellLate_q <= 1'b0;
                            nullSeen_q <= 1'b0;
                            relink_q <= 1'b1;
                            fetchBusy_q <= 1'b1;
                            fetchReq <= 1'b1;
                            fetchLinkOnly <= 1'b1;
                            fetchAddr <= lastAddr_q;
                        end
                    end
                    default: begin
                        cmdState_q <= CA_RESET;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Dispatch to the execution engine; tags let it finish out of order
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            execValid <= 1'b0;
            execTag <= '0;
            execCdb <= '0;
            execMaxLen <= '0;
            tagNext_q <= '0;
        end else begin
            execValid <= dispatch;
            if (dispatch) begin
                execTag <= tagNext_q;
                execCdb <= fetchCdb;
                execMaxLen <= fetchCdb[LEN_HI:LEN_LO];
                tagNext_q <= tagNext_q + 1'b1;
            end
        end
    end

    // Commands held locally; caps the fetch window at DEPTH
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            inFlight_q <= '0;
        end else if (busReset) begin
            inFlight_q <= '0;
        end else if (dispatch && !retire) begin
            inFlight_q <= inFlight_q + 1'b1;
        end else if (retire && !dispatch) begin
            inFlight_q <= inFlight_q - 1'b1;
        end
    end

    assign cmdState = cmdState_q;

    // ==========================================================
    // Read data and status return
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            blkWrValid <= 1'b0;
            blkWrData <= '0;
        end else begin
            blkWrValid <= rdValid;
            blkWrData <= rdData;
        end
    end

    // One status block per retired command, the cycle after execDone
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            statusValid <= 1'b0;
            statusAddr <= ADDR_ZERO;
            statusTag <= '0;
            statusSenseKey <= '0;
        end else begin
            statusValid <= retire;
            if (retire) begin
                statusAddr <= statusFifo_q;
                statusTag <= execDoneTag;
                statusSenseKey <= execSenseKey;
            end
        end
    end

    // ==========================================================
    // Microcode save; only one download is tracked at a time
    logic ucodePend_q;
    logic [TAG_W-1:0] ucodeTag_q;
    logic ucodeHit;

    assign ucodeHit = retire && ucodePend_q && (execDoneTag == ucodeTag_q);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ucodePend_q <= 1'b0;
            ucodeTag_q <= '0;
            nvCommit <= 1'b0;
            uaValid <= 1'b0;
            uaMask <= '0;
            uaSenseKey <= '0;
            uaAsc <= '0;
            uaAscq <= '0;
        end else begin
            // Image survives resets because only nvCommit replaces it
            nvCommit <= ucodeHit && execOk;
            uaValid <= ucodeHit && execOk && ((unsolEnable & ~(NINIT'(1) << ownerId_q)) != '0);
            if (ucodeHit && execOk) begin
                uaMask <= unsolEnable & ~(NINIT'(1) << ownerId_q);
                uaSenseKey <= SK_UNIT_ATTN;
                uaAsc <= ASC_UCODE_CHANGED;
                uaAscq <= ASCQ_UCODE_CHANGED;
            end
            if (ucodeHit) begin
                ucodePend_q <= 1'b0;
            end
            if (dispatch && isUcode) begin
                ucodePend_q <= 1'b1;
                ucodeTag_q <= tagNext_q;
            end
        end
    end

    // ==========================================================
    // Checks
    sequence s_nullFetched;
        fetchDone && fetchBusy_q && fetchNextNull;
    endsequence

    sequence s_bellInSuspend;
        cmdState_q == CA_SUSPENDED && doorbellWr;
    endsequence

    a_reset_agents: assert property (@(posedge clk) disable iff (sys_rst)
        busReset |=> cmdState_q == CA_RESET && mgmtState_q == MA_RESET)
        else $error("agents not in reset after bus reset");

    a_login_password: assert property (@(posedge clk) disable iff (sys_rst)
        loginRespValid |-> $past(passOk) && $past(loginDone))
        else $error("login accepted without valid password");

    a_ptr_activates: assert property (@(posedge clk) disable iff (sys_rst)
        cmdState_q == CA_RESET && orbPtrWr && mgmtState_q == MA_LOGGED && !busReset
        |=> cmdState_q == CA_ACTIVE ##1 fetchReq && fetchAddr == $past(orbPtrAddr, 2))
        else $error("pointer write did not start fetching");

    a_bell_reset_ignored: assert property (@(posedge clk) disable iff (sys_rst)
        cmdState_q == CA_RESET && doorbellWr && !orbPtrWr |=> cmdState_q == CA_RESET)
        else $error("doorbell acted in reset");

    a_fetch_window: assert property (@(posedge clk) disable iff (sys_rst)
        fetchReq && !fetchLinkOnly |-> $past(inFlight_q) != CNT_FULL && !$past(nullSeen_q))
        else $error("fetch past full window or null link");

    a_null_stops: assert property (@(posedge clk) disable iff (sys_rst || busReset)
        s_nullFetched and !relink_q |=> !fetchReq [*4])
        else $error("fetch continued after null link");

    a_suspend_drained: assert property (@(posedge clk) disable iff (sys_rst)
        cmdState_q == CA_ACTIVE ##1 cmdState_q == CA_SUSPENDED |-> $past(inFlight_q) == '0)
        else $error("suspended with commands in flight");

    a_bell_relink: assert property (@(posedge clk) disable iff (sys_rst || busReset)
        s_bellInSuspend |=> fetchReq && fetchLinkOnly && fetchAddr == $past(lastAddr_q)
        && cmdState_q == CA_ACTIVE)
        else $error("doorbell did not re-read last link");

    a_bell_active_drop: assert property (@(posedge clk) disable iff (sys_rst)
        cmdState_q == CA_ACTIVE && doorbellWr && !nullSeen_q && !bellLate_q |=> !bellLate_q)
        else $error("early doorbell was kept");

    a_status_each: assert property (@(posedge clk) disable iff (sys_rst)
        retire |=> statusValid && statusAddr == statusFifo_q)
        else $error("missing status block");

    a_ucode_commit: assert property (@(posedge clk) disable iff (sys_rst)
        nvCommit |-> $past(ucodeHit) && $past(execOk))
        else $error("microcode saved without success");

    a_ua_sense: assert property (@(posedge clk) disable iff (sys_rst)
        uaValid |-> uaSenseKey == SK_UNIT_ATTN && uaAsc == ASC_UCODE_CHANGED
        && uaMask[ownerId_q] == 1'b0 && nvCommit)
        else $error("bad unit attention");

    a_len_field: assert property (@(posedge clk) disable iff (sys_rst)
        dispatch |=> execMaxLen == $past(fetchCdb[LEN_HI:LEN_LO]))
        else $error("wrong maximum length");

endmodule : sbf_fetch_agent

// file: sim/sbf_host_model.sv
// Purpose: Initiator memory side: answers login block and request fetches.
// Assumes: Answers three cycles after each request, one request outstanding.
// Notes: Password, request and next-link lines not being answered flip every cycle so stale data never looks valid.
module sbf_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Scenario controls
    input wire logic [1:0] pwdSel,
    input wire logic patched,
    // Requests from the device
    input wire logic loginFetchReq,
    input wire logic fetchReq,
    input wire logic fetchLinkOnly,
    input wire logic [sbf_pkg::ADDR_W-1:0] fetchAddr,
    // Answers
    output logic loginDone,
    output logic [31:0] loginPassword,
    output logic [sbf_pkg::ADDR_W-1:0] loginRespAddrIn,
    output logic [sbf_pkg::ADDR_W-1:0] loginStatusAddrIn,
    output logic fetchDone,
    output logic fetchNextNull,
    output logic [sbf_pkg::ADDR_W-1:0] fetchNext,
    output logic [sbf_pkg::CDB_W-1:0] fetchCdb
);
    timeunit 1ns;
    timeprecision 1ps;
    import sbf_pkg::*;
    localparam logic [CDB_W-1:0] RD_CDB = 80'h2800_0000_0010_0000_0800;
    localparam logic [CDB_W-1:0] WB_CDB = 80'h3b05_0000_0000_0004_0000;
    logic [1:0] loginPipe, fetchPipe;
    logic linkQ;
    logic [ADDR_W-1:0] addrQ;
    // Delay line: a real initiator is never instant
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            loginPipe <= '0;
            fetchPipe <= '0;
        end else begin
            loginPipe <= {loginPipe[0], loginFetchReq};
            fetchPipe <= {fetchPipe[0], fetchReq};
        end
    end
    always_ff @(posedge clk) begin
        if (fetchReq) begin
            linkQ <= fetchLinkOnly;
            addrQ <= fetchAddr;
        end
    end
    // Answers; the list ends in a null link, patched to a third request on demand
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {loginDone, fetchDone, fetchNextNull} <= '0;
            {loginPassword, loginRespAddrIn, loginStatusAddrIn, fetchNext, fetchCdb} <= '0;
        end else begin
            loginDone <= loginPipe[1];
            fetchDone <= fetchPipe[1];
            loginPassword <= ~loginPassword;
            fetchCdb <= ~fetchCdb;
            fetchNext <= ~fetchNext;
            fetchNextNull <= ~fetchNextNull;
            if (loginPipe[1]) begin
                loginPassword <= pwdSel == 2'h1 ? 32'h1234_5678 : pwdSel == 2'h2 ? 32'h8765_4321 : 32'h0bad_0bad;
                loginRespAddrIn <= 48'h4000;
                loginStatusAddrIn <= 48'h5000;
            end
            if (fetchPipe[1]) begin
                fetchCdb <= addrQ == 48'h100 ? RD_CDB : WB_CDB;
                fetchNextNull <= linkQ ? !patched : addrQ != 48'h100;
                fetchNext <= linkQ ? 48'h300 : 48'h200;
            end
        end
    end
endmodule : sbf_host_model

// file: sim/tb_top.sv
// Purpose: Self-checking bench for the request fetch agent.
// Assumes: Execution engine answers are driven here by tag.
// Notes: One-cycle output pulses are counted by a monitor and judged afterwards.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sbf_pkg::*;
    localparam logic [ADDR_W-1:0] CMDB = 48'h0000_0002_0000;
    logic clk = 0, sys_rst = 1, busReset = 0, mgmtWr = 0, orbPtrWr = 0, doorbellWr = 0, patched = 0;
    logic [1:0] pwdSel = 0;
    logic [ADDR_W-1:0] mgmtAddr = 0, orbPtrAddr = 0, loginRespAddrIn, loginStatusAddrIn, loginFetchAddr;
    logic [ADDR_W-1:0] loginRespAddr, loginCmdBase, fetchAddr, fetchNext, statusAddr, linkAddr;
    logic loginFetchReq, loginDone, loginRespValid, loginReject, fetchReq, fetchLinkOnly, fetchDone;
    logic fetchNextNull, execValid, blkWrValid, statusValid, nvCommit, uaValid, execDone = 0, execOk = 0;
    logic rdValid = 0;
    logic [31:0] loginPassword, rdData = 0, blkWrData;
    logic [1:0] loginInitId = 2'h1;
    logic [CDB_W-1:0] fetchCdb, execCdb;
    logic [TAG_W-1:0] execTag, statusTag, execDoneTag = 0, lastTag, tags[$];
    logic [LEN_W-1:0] execMaxLen, lens[$];
    logic [3:0] execSenseKey = 0, statusSenseKey, uaSenseKey, uaMask;
    logic [3:0] unsolEnable = 4'b1011;
    logic [7:0] uaAsc, uaAscq;
    logic [1:0] cmdState;
    int mismatches = 0, nCompared = 0, nResp = 0, nRej = 0, nFetch = 0, nLink = 0, nStat = 0, nNv = 0;
    int nUa = 0, cycles = 0;
    sbf_fetch_agent #(.CMD_AGENT_BASE(CMDB)) DUT (.clk, .sys_rst, .busReset, .mgmtWr, .mgmtAddr, .orbPtrWr,
        .orbPtrAddr, .doorbellWr, .loginFetchReq, .loginFetchAddr, .loginDone, .loginPassword, .loginRespAddrIn,
        .loginStatusAddrIn, .loginInitId, .currentPassword(32'h1234_5678), .masterPassword(32'h8765_4321),
        .loginRespValid, .loginReject, .loginRespAddr, .loginCmdBase, .fetchReq, .fetchLinkOnly, .fetchAddr,
        .fetchDone, .fetchNextNull, .fetchNext, .fetchCdb, .execValid, .execTag, .execCdb, .execMaxLen, .execDone,
        .execDoneTag, .execOk, .execSenseKey, .rdValid, .rdData, .blkWrValid, .blkWrData, .statusValid,
        .statusAddr, .statusTag, .statusSenseKey, .unsolEnable, .nvCommit, .uaValid, .uaMask, .uaSenseKey, .uaAsc,
        .uaAscq, .cmdState);
    sbf_host_model host (.clk, .sys_rst, .pwdSel, .patched, .loginFetchReq, .fetchReq, .fetchLinkOnly, .fetchAddr,
        .loginDone, .loginPassword, .loginRespAddrIn, .loginStatusAddrIn, .fetchDone, .fetchNextNull, .fetchNext,
        .fetchCdb);
    // ==========================================================
    // Clock, pulse monitor and hang guard
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        nResp += loginRespValid === 1'b1;
        nRej += loginReject === 1'b1;
        nFetch += fetchReq === 1'b1;
        nStat += statusValid === 1'b1;
        nNv += nvCommit === 1'b1;
        nUa += uaValid === 1'b1;
        if (fetchReq === 1'b1 && fetchLinkOnly === 1'b1) begin
            nLink++;
            linkAddr = fetchAddr;
        end
        if (statusValid === 1'b1) lastTag = statusTag;
        if (execValid === 1'b1) begin
            tags.push_back(execTag);
            lens.push_back(execMaxLen);
        end
        if (cycles == 3000) begin
            mismatches++;
            close_out();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [79:0] seen, input logic [79:0] exp, input string msg);
        nCompared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc
    task automatic exec_done(input logic [TAG_W-1:0] t, input logic ok);
        @(posedge clk);
        {execDone, execDoneTag, execOk} <= {1'b1, t, ok};
        @(posedge clk);
        execDone <= 1'b0;
    endtask : exec_done
    task automatic login(input logic [1:0] sel, input int ok);
        int r0;
        int j0;
        r0 = nResp;
        j0 = nRej;
        @(posedge clk);
        {pwdSel, mgmtWr, mgmtAddr} <= {sel, 1'b1, 48'h1000};
        @(posedge clk);
        mgmtWr <= 1'b0;
        wait_cyc(8);
        check(loginFetchAddr, 48'h1000, "login block address");
        check(nResp - r0, ok, "login accept count");
        check(nRej - j0, 1 - ok, "login reject count");
        if (ok == 1) begin
            check(loginRespAddr, 48'h4000, "login response address");
            check(loginCmdBase, CMDB, "login command agent base");
        end
    endtask : login
    // ==========================================================
    // Scenarios
    task automatic test_list;
        doorbellWr <= 1'b1;
        wait_cyc(1);
        doorbellWr <= 1'b0;
        wait_cyc(6);
        check(cmdState, 2'h0, "doorbell in reset");
        check(nFetch, 0, "no fetch in reset");
        {orbPtrWr, orbPtrAddr} <= {1'b1, 48'h100};
        wait_cyc(1);
        orbPtrWr <= 1'b0;
        wait_cyc(1);
        check(cmdState, 2'h1, "active after pointer write");
        doorbellWr <= 1'b1;
        wait_cyc(1);
        doorbellWr <= 1'b0;
        wait_cyc(12);
        check(tags.size(), 2, "dispatch count");
        check(lens[1], 24'h000400, "download length");
        check(execCdb[79:64], 16'h3b05, "download request passed on");
        exec_done(tags[1], 1'b1);
        wait_cyc(2);
        check(cmdState, 2'h1, "active with work in flight");
        exec_done(tags[0], 1'b1);
        wait_cyc(10);
        check(cmdState, 2'h2, "suspended, early doorbell dropped");
        check(nStat, 2, "status block count");
        check({lastTag, statusAddr}, {tags[0], 48'h5000}, "status blocks");
        check({nNv, nUa}, {32'd1, 32'd1}, "commit and attention");
        check(uaMask, 4'b1001, "attention targets");
        check({uaSenseKey, uaAsc, uaAscq}, {SK_UNIT_ATTN, 8'h3f, 8'h01}, "attention sense");
    endtask : test_list
    task automatic test_append;
        {patched, doorbellWr} <= 2'b11;
        wait_cyc(1);
        doorbellWr <= 1'b0;
        wait_cyc(12);
        check({nLink, linkAddr}, {32'd1, 48'h200}, "old last link re-read");
        check(tags.size(), 3, "resumed at new offset");
        execSenseKey <= 4'h4;
        exec_done(tags[2], 1'b0);
        wait_cyc(6);
        check({nNv, nUa, cmdState}, {32'd1, 32'd1, 2'h2}, "failed download");
        check({statusTag, statusSenseKey}, {tags[2], 4'h4}, "failed command status");
        {rdValid, rdData} <= {1'b1, 32'hcafe_f00d};
        wait_cyc(1);
        rdValid <= 1'b0;
        check({blkWrValid, blkWrData}, {1'b1, 32'hcafe_f00d}, "block write data");
        busReset <= 1'b1;
        wait_cyc(1);
        busReset <= 1'b0;
        wait_cyc(1);
        check(cmdState, 2'h0, "bus reset");
    endtask : test_append
    task automatic close_out;
        $display("mismatches %0d compared %0d", mismatches, nCompared);
        if (mismatches == 0 && nCompared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        wait_cyc(1);
        check(cmdState, 2'h0, "reset state");
        login(2'h0, 0);
        login(2'h1, 1);
        test_list();
        test_append();
        login(2'h2, 1);
        close_out();
    end
endmodule : tb_top
